// ==== hw/slrc_pkg.sv ====
// Shared constants and carrier types of the serial link receiver
package slrc_pkg;

  // ==========================================================
  // Lane and buffer geometry
  localparam int LANE_CNT     = 16;  // Serial lanes of the link
  localparam int DSK_DEPTH    = 8;   // Deskew buffer entries per lane
  localparam int FIFO_DEPTH   = 16;  // Frame FIFO words
  localparam int FRAME_OCT    = 2;   // Octets per frame per lane
  localparam int LMFC_PERIOD  = 32;  // Cycles per local multiframe
  localparam int OCT_W        = 8;   // Bits per octet before coding

  // ==========================================================
  // Control characters of the 8b/10b link
  localparam logic [7:0] K_CGS = 8'hbc;  // Group sync character
  localparam logic [7:0] K_MFS = 8'h1c;  // Multiframe start in ILAS
  localparam logic [7:0] K_ALN = 8'h7c;  // Lane alignment character
  localparam logic [2:0] LOCK_CNT = 3'h4; // Hits needed for lock
  localparam logic [2:0] ILAS_MF  = 3'h4; // Multiframes of the ILAS

  // ==========================================================
  // Descrambler history and taps
  localparam int SCR_W   = 58;  // History length
  localparam int T8_A    = 13;  // Taps x^14 and x^15
  localparam int T8_B    = 14;
  localparam int T66_A   = 38;  // Taps x^39 and x^58
  localparam int T66_B   = 57;

  // ==========================================================
  // Link states, Gray coded along the usual path
  typedef enum logic [1:0] {
    LS_IDLE = 2'h0,
    LS_CGS  = 2'h1,
    LS_ILAS = 2'h3,
    LS_DATA = 2'h2
  } slrc_state_type;

  // One decoded octet of one lane
  typedef struct packed {
    logic       valid;  // Octet present
    logic       ctl;    // Control char or multiblock marker
    logic [7:0] octet;  // Octet value
  } slrc_lane_type;

  // One aligned word of all lanes
  typedef struct packed {
    logic                        frame_start;  // First octet of frame
    logic [LANE_CNT*OCT_W-1:0]   octets;       // Lane 0 in low bits
  } slrc_frame_type;

  // Lane PLL settings
  typedef struct packed {
    logic [7:0] ref_divider;
    logic [7:0] pll_multiplier;
    logic [1:0] lane_rate_divider;
    logic       vco_low_range_select;
  } slrc_pll_type;

endpackage : slrc_pkg

// ==== hw/slrc_fifo.sv ====
// Synchronous valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module slrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  // Filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  import slrc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [AW:0]      wr_q;           // Write pointer with wrap bit
  logic [AW:0]      rd_q;           // Read pointer with wrap bit
  logic             full_w;
  logic             empty_w;
  logic             push_w;
  logic             pop_w;

  // ==========================================================
  // Status
  assign empty_w       = (wr_q == rd_q);
  assign full_w        = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready_out  = !full_w;
  assign out_valid_out = !empty_w;
  assign push_w        = in_valid_in && !full_w;
  assign pop_w         = out_ready_in && !empty_w;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];

  // Storage write
  always_ff @(posedge core_clk_in) begin
    if (push_w) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push_w) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop_w) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule : slrc_fifo
`default_nettype wire

// ==== hw/slrc_rx.sv ====
// Serial link receiver: lane lock, SYNC, alignment, descrambler, framing
`timescale 1ns/1ps
`default_nettype none
module slrc_rx #(
  parameter int DESKEW_DEPTH = slrc_pkg::DSK_DEPTH,
  parameter int FIFO_DEPTH   = slrc_pkg::FIFO_DEPTH,
  parameter int FRAME_OCTETS = slrc_pkg::FRAME_OCT,
  parameter int LMFC_CYCLES  = slrc_pkg::LMFC_PERIOD
) (
  // Clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rstn_in,
  // Configuration
  input  wire logic                    link_enable_in,
  input  wire logic                    coding_66_in,
  input  wire logic                    descrambler_enable_in,
  input  wire logic                    timing_ref_align_enable_in,
  input  wire logic                    sysref_proc_enable_in,
  input  wire logic                    sync_timing_b_in,
  input  wire logic [15:0]             lane_enable_in,
  input  wire slrc_pkg::slrc_pll_type  pll_cfg_in,
  // Lanes and timing reference
  input  wire slrc_pkg::slrc_lane_type serial_lane_inputs_in [slrc_pkg::LANE_CNT],
  input  wire logic                    sysref_in,
  // Handshake to transmitter
  output logic                         sync_n_out,
  // Frame stream
  output logic                         frame_valid_out,
  input  wire logic                    frame_ready_in,
  output slrc_pkg::slrc_frame_type     frame_out,
  // Status
  output slrc_pkg::slrc_state_type     link_state_out,
  output logic [15:0]                  lanes_locked_out,
  output logic                         deskew_err_out,
  output logic                         lmfc_edge_out,
  output logic                         descr_active_out,
  output slrc_pkg::slrc_pll_type       pll_cfg_out
);
  import slrc_pkg::*;

  localparam int DAW = $clog2(DESKEW_DEPTH);
  localparam int LMW = $clog2(LMFC_CYCLES);
  localparam int FOW = $clog2(FRAME_OCTETS + 1);
  localparam logic [DAW:0]   DSK_FULL = (DAW+1)'(DESKEW_DEPTH);
  localparam logic [LMW-1:0] LMFC_TOP = LMW'(LMFC_CYCLES - 1);
  localparam logic [FOW-1:0] FO_TOP   = FOW'(FRAME_OCTETS - 1);

  // ==========================================================
  // Descrambler over one octet, MSB first
  function automatic logic [SCR_W+7:0] dscr(input logic [SCR_W-1:0] s,
                                            input logic [7:0] d,
                                            input logic m66);
    logic [SCR_W-1:0] h;
    logic [7:0]       o;
    h = s;
    o = '0;
    for (int b = 7; b >= 0; b--) begin
      // Feedback taps differ per coding
      o[b] = d[b] ^ (m66 ? (h[T66_A] ^ h[T66_B]) : (h[T8_A] ^ h[T8_B]));
      h    = {h[SCR_W-2:0], d[b]};
    end
    return {h, o};
  endfunction : dscr

  // ==========================================================
  // Shared state
  slrc_state_type   state_q;     // Link state
  logic             sync_n_q;    // SYNC pin level
  logic [LMW-1:0]   lmfc_q;      // Multiframe or multiblock counter
  logic             sysref_q;    // Previous timing reference level
  logic             sref_edge;   // Rising edge of timing reference
  logic             align_ok;    // Realignment allowed
  logic [DAW:0]     rptr_q;      // Common deskew read pointer
  logic [FOW-1:0]   fo_q;        // Octet index within frame
  logic             link_en_q;   // Previous link enable
  logic             err_q;       // Sticky deskew overflow
  slrc_pll_type     pll_q;       // Latched PLL settings
  logic             dscr_on;     // Descrambler active
  logic             pop;         // Aligned word leaves deskew
  logic             fifo_rdy;    // FIFO can take a word
  logic             all_locked;
  logic             all_start;
  logic             all_nemp;
  slrc_frame_type   push_word;
  wire  [15:0]      locked_w;
  wire  [15:0]      start_w;
  wire  [15:0]      nemp_w;
  wire  [15:0]      ovf_w;
  wire  [LANE_CNT*OCT_W-1:0] oct_w;

  // sixteen lanes, masked ones count ready
  assign all_locked = &(locked_w | ~lane_enable_in);
  assign all_start  = &(start_w | ~lane_enable_in);
  assign all_nemp   = &(nemp_w | ~lane_enable_in);

  assign dscr_on = coding_66_in | descrambler_enable_in;

  // ==========================================================
  // Per-lane lock, ILAS tracking, descrambler, deskew buffer
  // coding chosen per configuration
  // block path has no FEC or CRC3
  for (genvar i = 0; i < LANE_CNT; i++) begin : lane_g
    slrc_lane_type    ln;                         // Lane input
    logic [2:0]       lock_cnt_q;                 // Consecutive lock hits
    logic [2:0]       mf_cnt_q;                   // ILAS multiframes seen
    logic             start_q;                    // Data phase reached
    logic [SCR_W-1:0] scr_q;                      // Received bit history
    logic [7:0]       buf_q [DESKEW_DEPTH];       // Deskew storage
    logic [DAW:0]     wptr_q;                     // Lane write pointer
    logic [SCR_W+7:0] dsc;                        // Descrambled result
    logic             locked;
    logic             lock_hit;
    logic             ilas_end;
    logic             start_66;
    logic             full;
    logic             wr_en;

    assign ln     = serial_lane_inputs_in[i];
    assign locked = (lock_cnt_q == LOCK_CNT);
    assign lock_hit = coding_66_in ? ln.valid
                    : (ln.valid && ln.ctl && (ln.octet == K_CGS));
    // end of ILAS marks aligned boundary
    assign ilas_end = !coding_66_in && ln.valid && ln.ctl && locked
                    && (ln.octet == K_ALN) && (mf_cnt_q == ILAS_MF);
    assign start_66 = coding_66_in && ln.valid && ln.ctl && locked;
    assign full     = ((wptr_q - rptr_q) == DSK_FULL);
    assign wr_en    = ln.valid && locked && lane_enable_in[i]
                    && (start_q || start_66) && !full;
    assign dsc      = dscr(scr_q, ln.octet, coding_66_in);

    assign locked_w[i] = locked;
    assign start_w[i]  = start_q;
    assign nemp_w[i]   = (wptr_q != rptr_q);
    assign ovf_w[i]    = ln.valid && locked && start_q && full;
    assign oct_w[i*OCT_W +: OCT_W] = lane_enable_in[i] ? buf_q[rptr_q[DAW-1:0]] : 8'h00;

    // Lock counter, held once locked
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        lock_cnt_q <= 3'h0;
      end else if (state_q == LS_IDLE) begin
        lock_cnt_q <= 3'h0;
      end else if (!locked) begin
        lock_cnt_q <= lock_hit ? lock_cnt_q + 3'h1 : 3'h0;
      end
    end

    // ILAS multiframe count and data phase flag
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        mf_cnt_q <= 3'h0;
        start_q  <= 1'b0;
      end else if (state_q == LS_IDLE) begin
        mf_cnt_q <= 3'h0;
        start_q  <= 1'b0;
      end else begin
        if (ln.valid && ln.ctl && locked && (ln.octet == K_MFS)
            && (mf_cnt_q != ILAS_MF)) begin
          mf_cnt_q <= mf_cnt_q + 3'h1;
        end
        if (ilas_end || start_66) begin
          start_q <= 1'b1;
        end
      end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        scr_q <= '0;
      end else if (ln.valid) begin
        scr_q <= dsc[SCR_W+7:8];
      end
    end

    always_ff @(posedge core_clk_in) begin
      if (wr_en) begin
        buf_q[wptr_q[DAW-1:0]] <= dscr_on ? dsc[7:0] : ln.octet;
      end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        wptr_q <= '0;
      end else if (state_q == LS_IDLE) begin
        wptr_q <= '0;
      end else if (wr_en) begin
        wptr_q <= wptr_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Link state machine
  // all logic on the device clock
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= LS_IDLE;
    end else if (!link_enable_in) begin
      state_q <= LS_IDLE;
    end else begin
      case (state_q)
        LS_IDLE: begin
          state_q <= LS_CGS;
        end
        LS_CGS: begin
          if (all_locked && (coding_66_in || sync_n_q)) begin
            state_q <= LS_ILAS;
          end
        end
        LS_ILAS: begin
          if (all_start) begin
            state_q <= LS_DATA;
          end
        end
        LS_DATA: begin
          state_q <= LS_DATA;
        end
        default: begin
          state_q <= LS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // SYNC handshake
  // dedicated pin in 8b/10b
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_n_q <= 1'b1;
    end else if (coding_66_in || (state_q == LS_IDLE)) begin
      sync_n_q <= 1'b1;
    end else if (state_q == LS_CGS) begin
      if (!all_locked) begin
        sync_n_q <= 1'b0;
      end else if (!sync_timing_b_in || (lmfc_q == '0)) begin
        sync_n_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Multiframe counter and timing reference
  assign sref_edge = sysref_in && !sysref_q;
  assign align_ok  = link_enable_in && sysref_proc_enable_in && timing_ref_align_enable_in;

  // Edge detector history
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lmfc_q <= '0;
    end else if (sref_edge && align_ok) begin
      lmfc_q <= '0;
    end else if (lmfc_q == LMFC_TOP) begin
      lmfc_q <= '0;
    end else begin
      lmfc_q <= lmfc_q + 1'b1;
    end
  end

  // ==========================================================
  // Aligned read-out into the frame FIFO
  assign pop = (state_q == LS_DATA) && all_nemp && fifo_rdy;
  assign push_word.frame_start = (fo_q == '0);
  assign push_word.octets      = oct_w;

  // Common read pointer
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rptr_q <= '0;
    end else if (state_q == LS_IDLE) begin
      rptr_q <= '0;
    end else if (pop) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end

  // Octet position within the frame
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fo_q <= '0;
    end else if (state_q != LS_DATA) begin
      fo_q <= '0;
    end else if (pop) begin
      fo_q <= (fo_q == FO_TOP) ? '0 : fo_q + 1'b1;
    end
  end

  // Sticky overflow, cleared when link drops
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_q <= 1'b0;
    end else if (|(ovf_w & lane_enable_in)) begin
      err_q <= 1'b1;
    end else if (state_q == LS_IDLE) begin
      err_q <= 1'b0;
    end
  end

  // Frame buffer
  slrc_fifo #(
    .WIDTH ($bits(slrc_frame_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (pop),
    .in_ready_out  (fifo_rdy),
    .in_data_in    (push_word),
    .out_valid_out (frame_valid_out),
    .out_ready_in  (frame_ready_in),
    .out_data_out  (frame_out)
  );

  // ==========================================================
  // PLL settings captured at link enable
  // settings taken as link starts
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_en_q <= 1'b0;
      pll_q     <= '0;
    end else begin
      link_en_q <= link_enable_in;
      if (link_enable_in && !link_en_q) begin
        pll_q <= pll_cfg_in;
      end
    end
  end

  // Outputs
  assign sync_n_out       = sync_n_q;
  assign link_state_out   = state_q;
  assign lanes_locked_out = locked_w;
  assign deskew_err_out   = err_q;
  assign lmfc_edge_out    = (lmfc_q == '0);
  assign descr_active_out = dscr_on;
  assign pll_cfg_out      = pll_q;

  // ==========================================================
  // Assertions
  AST_SYNC_66_HIGH: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    coding_66_in |=> (sync_n_out || !$past(coding_66_in)))
    else $error("SYNC low in block coding");

  AST_SYNC_REQ: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (state_q == LS_CGS && !all_locked && !coding_66_in) |=> !sync_n_out)
    else $error("SYNC not low while lanes unlocked");

  AST_SYNC_B_EDGE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ($rose(sync_n_out) && $past(sync_timing_b_in) && $past(state_q == LS_CGS))
    |-> ($past(lmfc_q) == '0))
    else $error("SYNC released off boundary");

  AST_LMFC_RESET: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (sref_edge && align_ok) |=> (lmfc_q == '0) ##1 (lmfc_q == LMW'(1)))
    else $error("Counter not reset by timing edge");

  AST_LMFC_FREE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (sref_edge && !align_ok && lmfc_q != LMFC_TOP) |=> (lmfc_q == $past(lmfc_q) + 1'b1))
    else $error("Counter moved without alignment enable");

  AST_DSCR_66: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    coding_66_in |-> descr_active_out)
    else $error("Descrambler off in block coding");

  AST_POP_DATA: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    pop |-> (state_q == LS_DATA && all_start))
    else $error("Word read before alignment");

  AST_PLL_HOLD: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (link_en_q && link_enable_in) |=> $stable(pll_cfg_out))
    else $error("PLL settings changed while enabled");

  AST_FRAME_START: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (pop && fo_q == FO_TOP) |=> (fo_q == '0))
    else $error("Frame octet index did not wrap");

endmodule : slrc_rx
`default_nettype wire

// ==== test/slrc_tx_model.sv ====
// Behavioural transmitter that feeds decoded lane octets to the receiver
`timescale 1ns/1ps
`default_nettype none
module slrc_tx_model (
  // Clock and controls
  input  wire logic               core_clk_in,
  input  wire logic               link_enable_in,
  input  wire logic               coding_66_in,
  input  wire logic               pause_in,
  input  wire logic               scramble_in,
  // Handshake from receiver
  input  wire logic               sync_n_in,
  // Lanes towards receiver
  output slrc_pkg::slrc_lane_type lanes_out [slrc_pkg::LANE_CNT]
);
  import slrc_pkg::*;
  logic [1:0] phase_q;  // 0 wait, 1 group sync, 2 alignment, 3 data
  logic [3:0] cnt_q;    // Alignment or block count
  logic [7:0] oct;      // Octet of this cycle
  logic       ctl;      // Control flag of this cycle
  logic       vld;      // Valid flag of this cycle
  logic       descrambler_enable;      // Scramble this cycle
  logic       tap;      // Scrambler feedback bit
  logic [7:0] d;        // Lane octet being sent
  logic [SCR_W-1:0] sh [LANE_CNT] = '{default: '0};  // Sent bit history per lane
  // ==========================================================
  // Sequencer, moves just after each falling edge
  always @(negedge core_clk_in) begin
    // Settle past the bench's own falling-edge writes
    #1;
    if (!link_enable_in) begin
      phase_q = 2'h0;
      cnt_q   = 4'h0;
    end else if (coding_66_in) begin
      cnt_q   = (cnt_q == 4'h9) ? cnt_q : cnt_q + 4'h1;
      phase_q = 2'h2;
    end else begin
      if (phase_q == 2'h0 && !sync_n_in) phase_q = 2'h1;
      if (phase_q == 2'h1 && sync_n_in) begin
        phase_q = 2'h2;
        cnt_q   = 4'h0;
      end
    end
    // Idle and paused lines toggle instead of holding
    vld = 1'b1;
    ctl = 1'b0;
    oct = ~oct;
    if (coding_66_in && link_enable_in) begin
      ctl = (cnt_q == 4'h8);
      oct = 8'h30;
    end else if (phase_q == 2'h0) begin
      vld = 1'b0;
    end else if (phase_q == 2'h1) begin
      ctl = 1'b1;
      oct = K_CGS;
    end else if (phase_q == 2'h2) begin
      ctl   = 1'b1;
      oct   = (cnt_q < 4'h4) ? K_MFS : K_ALN;
      cnt_q = cnt_q + 4'h1;
      if (cnt_q == 4'h5) phase_q = 2'h3;
    end else if (pause_in) begin
      vld = 1'b0;
    end else begin
      oct = 8'ha0;
    end
    descrambler_enable = vld && (coding_66_in || (scramble_in && phase_q == 2'h3));
    for (int i = 0; i < LANE_CNT; i++) begin
      d = ctl ? oct : oct ^ 8'(i);
      for (int b = 7; b >= 0; b--) begin
        tap = coding_66_in ? (sh[i][T66_A] ^ sh[i][T66_B]) : (sh[i][T8_A] ^ sh[i][T8_B]);
        if (descrambler_enable) d[b] = d[b] ^ tap;
        if (vld) sh[i] = {sh[i][SCR_W-2:0], d[b]};
      end
      lanes_out[i] = '{vld, ctl, d};
    end
  end
endmodule : slrc_tx_model
`default_nettype wire

// ==== test/tb_slrc_rx.sv ====
// Self-checking testbench of the serial link receiver
`timescale 1ns/1ps
`default_nettype none
module tb_slrc_rx;
  import slrc_pkg::*;
  logic           core_clk_in, rstn_in, link_en, c66, descr_en, align_en, proc_en;
  logic           tsel, sysref, ready, pause, sync_n, fvalid, dsk_err, lmfc_edge, descr_act;
  logic [15:0]    lane_en, locked;
  slrc_pll_type   pll, pll_o;
  slrc_lane_type  lanes [LANE_CNT];
  slrc_frame_type frame;
  slrc_state_type state;
  int             bad_count, n_tests;
  // ==========================================================
  // Design and transmitter model
  slrc_rx dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .link_enable_in(link_en),
    .coding_66_in(c66), .descrambler_enable_in(descr_en),
    .timing_ref_align_enable_in(align_en), .sysref_proc_enable_in(proc_en),
    .sync_timing_b_in(tsel), .lane_enable_in(lane_en), .pll_cfg_in(pll),
    .serial_lane_inputs_in(lanes), .sysref_in(sysref), .sync_n_out(sync_n),
    .frame_valid_out(fvalid), .frame_ready_in(ready), .frame_out(frame),
    .link_state_out(state), .lanes_locked_out(locked), .deskew_err_out(dsk_err),
    .lmfc_edge_out(lmfc_edge), .descr_active_out(descr_act), .pll_cfg_out(pll_o));
  slrc_tx_model tx (.core_clk_in(core_clk_in), .link_enable_in(link_en), .coding_66_in(c66),
    .pause_in(pause), .scramble_in(descr_en), .sync_n_in(sync_n), .lanes_out(lanes));
  // ==========================================================
  // Shared checking tasks
  task automatic final_report;
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded waits; running out ends the run
  task automatic wait_bit(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) @(negedge core_clk_in);
    chk(s, v);
    if (s !== v) final_report();
  endtask : wait_bit
  task automatic wait_st(input slrc_state_type v, input int lim);
    for (int k = 0; k < lim && state !== v; k++) @(negedge core_clk_in);
    chk(state, v);
    if (state !== v) final_report();
  endtask : wait_st
  // ==========================================================
  // Scenarios
  task automatic t_link8;
    logic [127:0] e;
    for (int i = 0; i < 16; i++) e[i*8+:8] = 8'ha0 | 8'(i);
    chk(lmfc_edge, 1'b1);
    pll = '{8'h04, 8'h10, 2'h2, 1'b1};
    // First pass releases SYNC at once, second on the counter boundary
    for (int t = 0; t < 2; t++) begin
      link_en = 1'b0;
      tsel    = t[0];
      repeat (2) @(negedge core_clk_in);
      chk(sync_n, 1'b1);
      link_en = 1'b1;
      wait_bit(sync_n, 1'b0, 4);
      wait_st(LS_DATA, 80);
      chk(locked, 16'hffff);
      chk(sync_n, 1'b1);
      chk(pll_o, pll);
      chk(descr_act, 1'b0);
      wait_bit(fvalid, 1'b1, 10);
      chk(frame.octets, e);
      chk(frame.frame_start, 1'b1);
      @(negedge core_clk_in);
      chk(frame.frame_start, 1'b0);
    end
  endtask : t_link8
  task automatic t_sysref;
    logic [127:0] e;
    for (int i = 0; i < 16; i++) e[i*8+:8] = 8'ha0 | 8'(i);
    // Model scrambles data octets from here on
    descr_en = 1'b1;
    for (int a = 1; a >= 0; a--) begin
      align_en = a[0];
      wait_bit(lmfc_edge, 1'b1, 40);
      repeat (10) @(negedge core_clk_in);
      sysref = 1'b1;
      @(negedge core_clk_in);
      sysref = 1'b0;
      if (a == 1) begin
        wait_bit(lmfc_edge, 1'b1, 4);
        repeat (LMFC_PERIOD) @(negedge core_clk_in);
        chk(lmfc_edge, 1'b1);
      end else begin
        for (int k = 0; k < 4; k++) begin
          chk(lmfc_edge, 1'b0);
          @(negedge core_clk_in);
        end
      end
    end
    chk(descr_act, 1'b1);
    chk(frame.octets, e);
  endtask : t_sysref
  task automatic t_fifo;
    int k;
    ready = 1'b0;
    repeat (40) @(negedge core_clk_in);
    chk(fvalid, 1'b1);
    chk(dsk_err, 1'b1);
    pause = 1'b1;
    ready = 1'b1;
    for (k = 0; k < 80 && fvalid === 1'b1; k++) @(negedge core_clk_in);
    chk(k >= FIFO_DEPTH, 1'b1);
    chk(fvalid, 1'b0);
  endtask : t_fifo
  task automatic t_link66;
    logic         hi;
    logic [127:0] e;
    for (int i = 0; i < 16; i++) e[i*8+:8] = (i == 15) ? 8'h00 : 8'h30 | 8'(i);
    link_en  = 1'b0;
    descr_en = 1'b0;
    pause    = 1'b0;
    repeat (2) @(negedge core_clk_in);
    chk(dsk_err, 1'b0);
    c66     = 1'b1;
    lane_en = 16'h7fff;
    link_en = 1'b1;
    hi      = 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(negedge core_clk_in);
      hi = hi & sync_n;
    end
    chk(hi, 1'b1);
    wait_st(LS_DATA, 40);
    chk(descr_act, 1'b1);
    chk(locked[14:0], 15'h7fff);
    wait_bit(fvalid, 1'b1, 10);
    chk(frame.octets[127:120], 8'h00);
    chk(frame.octets, e);
  endtask : t_link66
  // ==========================================================
  // Clock, reset and main sequence
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  initial begin
    {rstn_in, link_en, c66, descr_en, align_en, tsel, sysref, pause} = '0;
    {proc_en, ready} = 2'b11;
    lane_en   = 16'hffff;
    pll       = '0;
    bad_count = 0;
    n_tests   = 0;
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rstn_in = 1'b1;
    t_link8();
    t_sysref();
    t_fifo();
    t_link66();
    final_report();
  end
endmodule : tb_slrc_rx
`default_nettype wire
